// ===== shared/awd_params.svh
/*
 * constants for the result formatter and window detector: register
 * addresses, field positions, reset values.
 * assumes it is included by bare name in each file that uses it; the guard skips repeats.
 */
`ifndef AWD_PARAMS_SVH
`define AWD_PARAMS_SVH

// special function register addresses
`define AWD_ADDR_UPPER_LOW 8'hc4
`define AWD_ADDR_UPPER_HIGH 8'hc5
`define AWD_ADDR_LOWER_LOW 8'hc6
`define AWD_ADDR_LOWER_HIGH 8'hc7
`define AWD_ADDR_CONTROL 8'he8
`define AWD_ADDR_RESULT_HIGH 8'hbf
`define AWD_ADDR_RESULT_LOW 8'hbe

// control register fields
`define AWD_BIT_JUSTIFY 0
`define AWD_BIT_MATCH 1

// reset values
`define AWD_RST_UPPER 8'hff
`define AWD_RST_LOWER 8'h00
`define AWD_RST_WORD 16'h0000
`define AWD_RST_BYTE 8'h00
`define AWD_RST_BIT 1'b0

// formatter constants
`define AWD_ZERO_NIBBLE 4'h0

`endif

// ===== shared/awd_pkg.sv
/*
 * types shared by the formatter and window detector.
 * assumes awd_params.svh holds the numeric constants.
 */
package awd_pkg;

    // one conversion handed over by the converter core
    typedef struct packed {
        logic valid;        // end of conversion, one cycle
        logic diff;         // differential reading
        logic [11:0] data;  // raw 12-bit result
    } awd_conv_t;

    // register access from the processor side
    typedef struct packed {
        logic wr;           // write strobe
        logic rd;           // read strobe
        logic [7:0] addr;   // register address
        logic [7:0] wdata;  // write data
    } awd_sfr_req_t;

endpackage : awd_pkg

// ===== hdl/awd_formatter.sv
/*
 * formatter: turns a raw 12-bit result into the 16-bit data word.
 * assumes the caller registers the word; purely combinational.
 */
`include "awd_params.svh"

module awd_formatter (
    // raw result
    input wire logic [11:0] data_i,
    input wire logic diff_i,
    input wire logic justify_i,
    // formatted word
    output logic [15:0] word_o
);
    import awd_pkg::*;

    // pick the layout from the justify select
    always_comb begin
        if (justify_i) begin
            word_o = {data_i, `AWD_ZERO_NIBBLE};
        end else if (diff_i) begin
            // sign extension of result bit 11
            word_o = {{4{data_i[11]}}, data_i};
        end else begin
            word_o = {`AWD_ZERO_NIBBLE, data_i};
        end
    end

endmodule // awd_formatter

// ===== hdl/awd_window_detect.sv
/*
 * result formatter and programmable window detector with its register file.
 * assumes strobes and results are synchronous to clock_i; the converter
 * core pulses conv_i.valid for one cycle per finished conversion.
 */
`include "awd_params.svh"

module awd_window_detect (
    // clock and reset
    input wire logic clock_i,
    input wire logic rst_n_i,
    // converter core
    input wire awd_pkg::awd_conv_t conv_i,
    // register port
    input wire awd_pkg::awd_sfr_req_t sfr_i,
    output logic [7:0] sfr_rdata_o,
    // status
    output logic [15:0] data_word_o,
    output logic window_match_flag_o,
    output logic justify_select_o
);
    import awd_pkg::*;

    // unsigned compares, used for both limits
    function automatic logic above(input logic [15:0] a, input logic [15:0] b);
        above = (a > b);
    endfunction

    // stored state
    logic [7:0] upper_limit_high_r, upper_limit_high_nxt;
    logic [7:0] upper_limit_low_r, upper_limit_low_nxt;
    logic [7:0] lower_limit_high_r, lower_limit_high_nxt;
    logic [7:0] lower_limit_low_r, lower_limit_low_nxt;
    logic justify_r, justify_nxt;         // control bit zero
    logic match_r, match_nxt;             // control bit one
    logic [15:0] word_r, word_nxt;        // result high:low bytes
    logic [7:0] rdata_r, rdata_nxt;       // registered read data

    // derived views
    logic [15:0] upper_word;              // greater-than limit
    logic [15:0] lower_word;              // less-than limit
    logic [15:0] fmt_word;                // new result, formatted now
    logic inband_hit;                     // inside-window match
    logic outband_hit;                    // outside-window match
    logic match_set;                      // hardware set event
    logic ctrl_wr;                        // control register write

    assign upper_word = {upper_limit_high_r, upper_limit_low_r};
    assign lower_word = {lower_limit_high_r, lower_limit_low_r};
    assign ctrl_wr = sfr_i.wr && (sfr_i.addr == `AWD_ADDR_CONTROL);

    // formats with the justify bit in force at end of conversion
    awd_formatter u_fmt (
        .data_i(conv_i.data),
        .diff_i(conv_i.diff),
        .justify_i(justify_r),
        .word_o(fmt_word)
    );

    // window decision on the fresh word, not the stale register
    always_comb begin
        // inside band when lower limit above upper
        inband_hit = above(lower_word, upper_word) && above(fmt_word, upper_word)
            && above(lower_word, fmt_word);
        // outside band otherwise; equal limits fall here
        outband_hit = !above(lower_word, upper_word)
            && (above(lower_word, fmt_word) || above(fmt_word, upper_word));
        // only a new conversion may raise the hardware set of the flag
        match_set = conv_i.valid && (inband_hit || outband_hit);
    end

    // next values of registers, flag and read data
    always_comb begin
        upper_limit_high_nxt = upper_limit_high_r;
        upper_limit_low_nxt = upper_limit_low_r;
        lower_limit_high_nxt = lower_limit_high_r;
        lower_limit_low_nxt = lower_limit_low_r;
        justify_nxt = justify_r;
        match_nxt = match_r;
        word_nxt = word_r;
        rdata_nxt = rdata_r;
        // address decode for writes; result bytes are read only
        if (sfr_i.wr) begin
            if (sfr_i.addr == `AWD_ADDR_UPPER_LOW) begin
                upper_limit_low_nxt = sfr_i.wdata;
            end else if (sfr_i.addr == `AWD_ADDR_UPPER_HIGH) begin
                upper_limit_high_nxt = sfr_i.wdata;
            end else if (sfr_i.addr == `AWD_ADDR_LOWER_LOW) begin
                lower_limit_low_nxt = sfr_i.wdata;
            end else if (sfr_i.addr == `AWD_ADDR_LOWER_HIGH) begin
                lower_limit_high_nxt = sfr_i.wdata;
            end else if (sfr_i.addr == `AWD_ADDR_CONTROL) begin
                justify_nxt = sfr_i.wdata[`AWD_BIT_JUSTIFY];
                match_nxt = sfr_i.wdata[`AWD_BIT_MATCH];
            end
        end
        // hardware only sets; a set beats a same-cycle clear
        if (match_set) begin
            match_nxt = 1'b1;
        end
        // new word captured at end of conversion
        if (conv_i.valid) begin
            word_nxt = fmt_word;
        end
        // read decode; unmapped addresses answer zero
        if (sfr_i.rd) begin
            if (sfr_i.addr == `AWD_ADDR_UPPER_LOW) begin
                rdata_nxt = upper_limit_low_r;
            end else if (sfr_i.addr == `AWD_ADDR_UPPER_HIGH) begin
                rdata_nxt = upper_limit_high_r;
            end else if (sfr_i.addr == `AWD_ADDR_LOWER_LOW) begin
                rdata_nxt = lower_limit_low_r;
            end else if (sfr_i.addr == `AWD_ADDR_LOWER_HIGH) begin
                rdata_nxt = lower_limit_high_r;
            end else if (sfr_i.addr == `AWD_ADDR_CONTROL) begin
                rdata_nxt = `AWD_RST_BYTE;
                rdata_nxt[`AWD_BIT_MATCH] = match_r;
                rdata_nxt[`AWD_BIT_JUSTIFY] = justify_r;
            end else if (sfr_i.addr == `AWD_ADDR_RESULT_HIGH) begin
                rdata_nxt = word_r[15:8];
            end else if (sfr_i.addr == `AWD_ADDR_RESULT_LOW) begin
                rdata_nxt = word_r[7:0];
            end else begin
                rdata_nxt = `AWD_RST_BYTE;
            end
        end
    end

    // register everything
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            // upper limit resets to all ones
            upper_limit_high_r <= `AWD_RST_UPPER;
            upper_limit_low_r <= `AWD_RST_UPPER;
            // lower limit resets to all zeros
            lower_limit_high_r <= `AWD_RST_LOWER;
            lower_limit_low_r <= `AWD_RST_LOWER;
            justify_r <= `AWD_RST_BIT;
            match_r <= `AWD_RST_BIT;
            word_r <= `AWD_RST_WORD;
            rdata_r <= `AWD_RST_BYTE;
        end else begin
            upper_limit_high_r <= upper_limit_high_nxt;
            upper_limit_low_r <= upper_limit_low_nxt;
            lower_limit_high_r <= lower_limit_high_nxt;
            lower_limit_low_r <= lower_limit_low_nxt;
            justify_r <= justify_nxt;
            match_r <= match_nxt;
            word_r <= word_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // outputs straight from flops
    assign sfr_rdata_o = rdata_r;
    assign data_word_o = word_r;
    assign window_match_flag_o = match_r;
    assign justify_select_o = justify_r;

    // checks on the behaviour above
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);

    fmt_right_a: assert property (conv_i.valid && !justify_r |=>
        word_r == {($past(conv_i.diff) ? {4{$past(conv_i.data[11])}} : 4'h0), $past(conv_i.data)})
        else $error("right justified word wrong");
    sign_ext_a: assert property (conv_i.valid && !justify_r && conv_i.diff && conv_i.data[11] |=>
        word_r[15:12] == 4'hf)
        else $error("sign extension missing");
    fmt_left_a: assert property (conv_i.valid && justify_r |=>
        word_r == {$past(conv_i.data), 4'h0})
        else $error("left justified word wrong");
    full_scale_a: assert property (conv_i.valid && !conv_i.diff && conv_i.data == 12'hfff |=>
        word_r == ($past(justify_r) ? 16'hfff0 : 16'h0fff))
        else $error("full scale word wrong");
    inband_set_a: assert property (conv_i.valid && lower_word > upper_word &&
        fmt_word > upper_word && fmt_word < lower_word |=> match_r)
        else $error("inside band match not flagged");
    outband_set_a: assert property (conv_i.valid && lower_word <= upper_word &&
        (fmt_word < lower_word || fmt_word > upper_word) |=> match_r)
        else $error("outside band match not flagged");
    no_spurious_a: assert property (!match_r && !ctrl_wr && !(conv_i.valid &&
        (inband_hit || outband_hit)) |=> !match_r)
        else $error("flag set without match");
    flag_sticky_a: assert property (match_r && !ctrl_wr |=> match_r)
        else $error("flag cleared by hardware");
    flag_read_a: assert property (sfr_i.rd && sfr_i.addr == `AWD_ADDR_CONTROL |=>
        sfr_rdata_o[`AWD_BIT_MATCH] == $past(match_r) && sfr_rdata_o[`AWD_BIT_JUSTIFY] == $past(justify_r))
        else $error("control read wrong");
    limit_write_a: assert property (sfr_i.wr && sfr_i.addr == `AWD_ADDR_UPPER_HIGH |=>
        upper_word[15:8] == $past(sfr_i.wdata))
        else $error("upper limit write lost");
    lower_write_a: assert property (sfr_i.wr && sfr_i.addr == `AWD_ADDR_LOWER_LOW |=>
        lower_word[7:0] == $past(sfr_i.wdata))
        else $error("lower limit write lost");
    upper_low_write_a: assert property (sfr_i.wr && sfr_i.addr == `AWD_ADDR_UPPER_LOW |=>
        upper_word[7:0] == $past(sfr_i.wdata))
        else $error("upper limit low write lost");
    lower_high_write_a: assert property (sfr_i.wr && sfr_i.addr == `AWD_ADDR_LOWER_HIGH |=>
        lower_word[15:8] == $past(sfr_i.wdata))
        else $error("lower limit high write lost");
    justify_write_a: assert property (ctrl_wr |=>
        justify_r == $past(sfr_i.wdata[`AWD_BIT_JUSTIFY]))
        else $error("justify select write lost");
    result_read_a: assert property (sfr_i.rd && sfr_i.addr == `AWD_ADDR_RESULT_HIGH |=>
        sfr_rdata_o == $past(word_r[15:8]))
        else $error("result high byte read wrong");

    // scenarios worth seeing at least once
    cov_inband_c: cover property (conv_i.valid && inband_hit);
    cov_outband_c: cover property (conv_i.valid && outband_hit);
    cov_left_c: cover property (conv_i.valid && justify_r);
    cov_set_clear_c: cover property (match_set && ctrl_wr && !sfr_i.wdata[`AWD_BIT_MATCH]);
    cov_sw_set_c: cover property (ctrl_wr && sfr_i.wdata[`AWD_BIT_MATCH] && !match_r);

endmodule // awd_window_detect

// ===== testbench/awd_conv_model.sv
/*
 * converter core stand-in: hands one finished conversion per call.
 * assumes the bench calls convert() and drives nothing else on conv_o.
 */
module awd_conv_model (
    // clock
    input wire logic clock_i,
    // conversion out
    output awd_pkg::awd_conv_t conv_o
);
    timeunit 1ns;
    timeprecision 100ps;
    import awd_pkg::*;

    // idle at time zero
    initial begin
        conv_o = '0;
    end

    // one-cycle end-of-conversion pulse, launched off the falling edge
    task automatic convert(input logic [11:0] d, input logic diff);
        @(negedge clock_i);
        conv_o = {1'b1, diff, d};
        @(negedge clock_i);
        // lines no longer valid: show the inverse so stale data cannot pass
        conv_o = {1'b0, ~diff, ~d};
    endtask
endmodule // awd_conv_model

// ===== testbench/adc_result_format_window_detect_bench.sv
/*
 * self-checking bench for the formatter and window detector.
 * assumes the design's own assertions watch timing; this checks values.
 */
`include "awd_params.svh"

module adc_result_format_window_detect_bench;
    timeunit 1ns;
    timeprecision 100ps;
    import awd_pkg::*;

    logic clock_i = 1'b0;
    logic rst_n_i = 1'b0;
    awd_conv_t conv;
    awd_sfr_req_t sfr = '0;
    logic [7:0] sfr_rdata;
    logic [15:0] data_word;
    logic match_flag;
    logic justify;
    int n_errors = 0;
    int num_checks = 0;
    // justify, diff, raw, expected word
    logic [29:0] fmt_tab [7] = '{{2'b00, 12'hfff, 16'h0fff}, {2'b00, 12'h800, 16'h0800},
        {2'b01, 12'h800, 16'hf800}, {2'b01, 12'h7ff, 16'h07ff}, {2'b10, 12'hfff, 16'hfff0},
        {2'b10, 12'h800, 16'h8000}, {2'b11, 12'h7ff, 16'h7ff0}};
    // justify, lower, upper, missing raw, hitting raw
    logic [56:0] win_tab [3] = '{{1'b0, 16'h0200, 16'h0100, 12'h100, 12'h1ff},
        {1'b0, 16'h0100, 16'h0200, 12'h200, 12'h0ff}, {1'b1, 16'h2000, 16'h1000, 12'h200, 12'h101}};

    // 125 MHz system clock
    always #4 clock_i = ~clock_i;

    awd_window_detect dut (.clock_i(clock_i), .rst_n_i(rst_n_i), .conv_i(conv), .sfr_i(sfr),
        .sfr_rdata_o(sfr_rdata), .data_word_o(data_word), .window_match_flag_o(match_flag),
        .justify_select_o(justify));

    awd_conv_model conv_model (.clock_i(clock_i), .conv_o(conv));

    // single comparison point, four-state exact
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // one-cycle write strobe
    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        @(negedge clock_i);
        sfr = {1'b1, 1'b0, addr, data};
        @(negedge clock_i);
        sfr.wr = 1'b0;
    endtask

    // one-cycle read strobe, data one cycle later
    task automatic rd(input logic [7:0] addr, input logic [7:0] exp);
        @(negedge clock_i);
        sfr = {1'b0, 1'b1, addr, 8'h00};
        @(negedge clock_i);
        sfr.rd = 1'b0;
        check($sformatf("read %h", addr), {8'h00, sfr_rdata}, {8'h00, exp});
    endtask

    // limits are written a byte at a time
    task automatic set_limits(input logic [15:0] lower, input logic [15:0] upper);
        wr(`AWD_ADDR_LOWER_HIGH, lower[15:8]);
        wr(`AWD_ADDR_LOWER_LOW, lower[7:0]);
        wr(`AWD_ADDR_UPPER_HIGH, upper[15:8]);
        wr(`AWD_ADDR_UPPER_LOW, upper[7:0]);
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // watchdog: the tests need well under 20000 cycles
    initial begin
        #(20000 * 8);
        n_errors++;
        complete_run();
    end

    initial begin
        repeat (6) @(negedge clock_i);
        rst_n_i = 1'b1;
        // upper limit bytes reset to all ones
        rd(`AWD_ADDR_UPPER_LOW, 8'hff);
        rd(`AWD_ADDR_UPPER_HIGH, 8'hff);
        // unmapped read right after an all-ones read, so stale data would show
        rd(8'h00, 8'h00);
        // lower limit bytes reset to all zeros
        rd(`AWD_ADDR_LOWER_LOW, 8'h00);
        rd(`AWD_ADDR_LOWER_HIGH, 8'h00);
        // formatting table; reset limits never match, so the flag stays low
        foreach (fmt_tab[i]) begin
            wr(`AWD_ADDR_CONTROL, {7'h00, fmt_tab[i][29]});
            conv_model.convert(fmt_tab[i][27:16], fmt_tab[i][28]);
            check("data word", data_word, fmt_tab[i][15:0]);
            check("justify", {15'h0, justify}, {15'h0, fmt_tab[i][29]});
            rd(`AWD_ADDR_RESULT_HIGH, fmt_tab[i][15:8]);
            rd(`AWD_ADDR_RESULT_LOW, fmt_tab[i][7:0]);
        end
        check("flag", {15'h0, match_flag}, 16'h0000);
        // window modes: a boundary miss, a hit, then a miss that must not clear
        foreach (win_tab[i]) begin
            wr(`AWD_ADDR_CONTROL, {7'h00, win_tab[i][56]});
            set_limits(win_tab[i][55:40], win_tab[i][39:24]);
            rd(`AWD_ADDR_LOWER_HIGH, win_tab[i][55:48]);
            rd(`AWD_ADDR_UPPER_LOW, win_tab[i][31:24]);
            conv_model.convert(win_tab[i][23:12], 1'b0);
            check("flag miss", {15'h0, match_flag}, 16'h0000);
            conv_model.convert(win_tab[i][11:0], 1'b0);
            check("flag hit", {15'h0, match_flag}, 16'h0001);
            conv_model.convert(win_tab[i][23:12], 1'b0);
            check("flag sticky", {15'h0, match_flag}, 16'h0001);
            rd(`AWD_ADDR_CONTROL, {6'h00, 1'b1, win_tab[i][56]});
            wr(`AWD_ADDR_CONTROL, 8'h00);
            check("flag cleared", {15'h0, match_flag}, 16'h0000);
        end
        // a match beats a software clear in the same cycle; outside-band mode
        set_limits(16'h0100, 16'h0200);
        fork
            wr(`AWD_ADDR_CONTROL, 8'h00);
            conv_model.convert(12'h0ff, 1'b0);
        join
        check("flag set wins", {15'h0, match_flag}, 16'h0001);
        // write the flag bit as one, with left justify; the flag is still set from the match above
        wr(`AWD_ADDR_CONTROL, 8'h03);
        rd(`AWD_ADDR_CONTROL, 8'h03);
        check("justify set", {15'h0, justify}, 16'h0001);
        // mid-run reset: state goes back to its reset values
        @(negedge clock_i);
        rst_n_i = 1'b0;
        repeat (2) @(negedge clock_i);
        check("flag in reset", {15'h0, match_flag}, 16'h0000);
        check("word in reset", data_word, 16'h0000);
        rst_n_i = 1'b1;
        rd(`AWD_ADDR_UPPER_HIGH, 8'hff);
        rd(`AWD_ADDR_LOWER_LOW, 8'h00);
        rd(`AWD_ADDR_CONTROL, 8'h00);
        complete_run();
    end
endmodule // adc_result_format_window_detect_bench
